// File: global_clock_net_ctrl.sv
// global clock control block with two pll output counter models
`timescale 1ns/1ps
module global_clock_net_ctrl
	import global_clock_net_ctrl_pkg::*;
#(
	parameter int CNT_HIGH = 2,
	parameter int CNT_LOW = 2,
	parameter logic [NUM_PLL-1:0][NUM_CNT-1:0][CNT_W-1:0] CNT_INIT =
		'{default: 8'h01},
	parameter logic [NUM_PLL-1:0][NUM_CNT-1:0][TAP_W-1:0] TAP_INIT =
		'{default: 3'h0},
	parameter logic [CNT_SEL_W-1:0] SRC_A0 = 3'h0,
	parameter logic [CNT_SEL_W-1:0] SRC_A1 = 3'h1,
	parameter logic [CNT_SEL_W-1:0] SRC_B0 = 3'h0,
	parameter logic [CNT_SEL_W-1:0] SRC_B1 = 3'h1,
	parameter logic CFG_CLKSWITCH = 1'b0,
	parameter logic PLL1_UPSTREAM_ONLY = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [1:0] i_clk_select,
	input wire logic i_net_enable,
	input wire logic [1:0] i_ref_clk,
	output logic o_global_clock_net,
	output logic o_pll0_in,
	output logic o_pll1_in,
	output logic o_scan_clk,
	output logic [NUM_PLL*NUM_CNT-1:0] o_pll_clk
);

	localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(CNT_HIGH - 1);
	localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(CNT_LOW - 1);
	localparam int SCAN_CYC = 2 * SCAN_HALF;

	typedef struct packed {
		logic [TAP_W-1:0] vco_phase;
		logic [NUM_PLL-1:0][NUM_CNT-1:0][TAP_W-1:0] tap;
		logic [NUM_PLL-1:0][NUM_CNT-1:0][CNT_W-1:0] dly;
		logic [NUM_PLL-1:0][NUM_CNT-1:0][CNT_W-1:0] cnt;
		logic [NUM_PLL-1:0][NUM_CNT-1:0] run;
		logic [NUM_PLL-1:0][NUM_CNT-1:0] outc;
		logic [CTRL_W-1:0] ctrl;
		sw_state_type sw;
		logic [1:0] cur_sel;
		logic on;
		logic gate;
		logic net;
		ph_state_type ph;
		logic ph_up;
		logic ph_pll;
		logic [CNT_SEL_W-1:0] ph_cnt;
		logic [SCAN_W-1:0] scan_div;
		logic scan_clk;
		logic casc_active;
		logic casc_refused;
		logic pll0_in;
		logic pll1_in;
		logic [31:0] prdata;
	} state_type;

	logic rst_meta;
	logic rst_sync;
	state_type q;
	state_type next_q;
	logic [3:0] cand;
	logic [NUM_PLL-1:0][NUM_CNT-1:0] tick;
	logic clkswitch;
	logic scan_rise;
	logic setup_rd;
	logic wr_en;
	logic mapped;
	logic [31:0] rd_value;

	////////////////////////////////////////////////////////////////////////
	// reset release through two flip-flops
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fixed routing and decodes
	always_comb begin
		cand[0] = q.outc[0][SRC_A0];
		cand[1] = q.outc[0][SRC_A1];
		cand[2] = q.outc[1][SRC_B0];
		cand[3] = q.outc[1][SRC_B1];
		for (int p = 0; p < NUM_PLL; p++) begin
			for (int k = 0; k < NUM_CNT; k++) begin
				tick[p][k] = (q.vco_phase == q.tap[p][k]);
			end
		end
		// static switch unless manual switchover is enabled
		clkswitch = q.ctrl[CTRL_MANUAL] ? q.ctrl[CTRL_SWITCH]
			: CFG_CLKSWITCH;
		scan_rise = (q.scan_div == SCAN_LAST) && !q.scan_clk;
		setup_rd = i_psel && !i_penable && !i_pwrite;
		wr_en = i_psel && i_penable && i_pwrite;
		mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_PHASE)
			|| (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_TAP0)
			|| (i_paddr == ADDR_TAP1);
		rd_value = 32'h0;
		case (i_paddr)
			ADDR_CTRL: rd_value[CTRL_W-1:0] = q.ctrl;
			ADDR_PHASE: begin
				rd_value[PH_GO] = (q.ph != PS_IDLE);
				rd_value[PH_UP] = q.ph_up;
				rd_value[PH_PLL] = q.ph_pll;
				rd_value[PH_CNT_LSB +: CNT_SEL_W] = q.ph_cnt;
			end
			ADDR_STATUS: begin
				rd_value[ST_SEL_LSB +: 2] = q.cur_sel;
				rd_value[ST_ON] = q.on;
				rd_value[ST_SWITCHING] = (q.sw != SW_RUN);
				rd_value[ST_PH_BUSY] = (q.ph != PS_IDLE);
				rd_value[ST_CASC] = q.casc_active;
				rd_value[ST_CASC_REFUSED] = q.casc_refused;
			end
			ADDR_TAP0: rd_value[NUM_CNT*TAP_W-1:0] = q.tap[0];
			ADDR_TAP1: rd_value[NUM_CNT*TAP_W-1:0] = q.tap[1];
			default: rd_value = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_q = q;
		// vco phase walks the eight taps once per vco period
		next_q.vco_phase = q.vco_phase + TAP_ONE;
		// five output counters per pll
		for (int p = 0; p < NUM_PLL; p++) begin
			for (int k = 0; k < NUM_CNT; k++) begin
				if (tick[p][k]) begin
					if (!q.run[p][k]) begin
						if (q.dly[p][k] <= CNT_ONE) begin
							next_q.run[p][k] = 1'b1;
							next_q.outc[p][k] = 1'b1;
							next_q.cnt[p][k] = CNT_ZERO;
						end else begin
							next_q.dly[p][k] = q.dly[p][k] - CNT_ONE;
						end
					end else if (q.outc[p][k] && q.cnt[p][k] == HIGH_LAST) begin
						next_q.outc[p][k] = 1'b0;
						next_q.cnt[p][k] = CNT_ZERO;
					end else if (!q.outc[p][k] && q.cnt[p][k] == LOW_LAST) begin
						next_q.outc[p][k] = 1'b1;
						next_q.cnt[p][k] = CNT_ZERO;
					end else begin
						next_q.cnt[p][k] = q.cnt[p][k] + CNT_ONE;
					end
				end
			end
		end
		// scan clock divider
		if (q.scan_div == SCAN_LAST) begin
			next_q.scan_div = SCAN_ZERO;
			next_q.scan_clk = !q.scan_clk;
		end else begin
			next_q.scan_div = q.scan_div + 4'h1;
		end
		// dynamic phase step, one tap per scan clock period
		case (q.ph)
			PS_IDLE: begin
				if (wr_en && i_paddr == ADDR_PHASE && i_pwdata[PH_GO]) begin
					next_q.ph = PS_ALIGN;
					next_q.ph_up = i_pwdata[PH_UP];
					next_q.ph_pll = i_pwdata[PH_PLL];
					next_q.ph_cnt = i_pwdata[PH_CNT_LSB +: CNT_SEL_W];
				end
			end
			PS_ALIGN: begin
				if (scan_rise) begin
					next_q.ph = PS_STEP;
				end
			end
			PS_STEP: begin
				if (scan_rise) begin
					next_q.ph = PS_IDLE;
					if (q.ph_cnt < CNT_SEL_W'(NUM_CNT)) begin
						next_q.tap[q.ph_pll][q.ph_cnt] = q.ph_up
							? q.tap[q.ph_pll][q.ph_cnt] + TAP_ONE
							: q.tap[q.ph_pll][q.ph_cnt] - TAP_ONE;
					end
				end
			end
			default: next_q.ph = PS_IDLE;
		endcase
		// glitch-free source and enable changes
		case (q.sw)
			SW_RUN: begin
				if (i_clk_select != q.cur_sel || i_net_enable != q.on) begin
					next_q.sw = SW_OFF_WAIT;
				end
			end
			SW_OFF_WAIT: begin
				if (!q.gate || !cand[q.cur_sel]) begin
					next_q.gate = 1'b0;
					next_q.cur_sel = i_clk_select;
					next_q.on = i_net_enable;
					next_q.sw = SW_ON_WAIT;
				end
			end
			SW_ON_WAIT: begin
				if (!q.on) begin
					next_q.sw = SW_RUN;
				end else if (!cand[q.cur_sel]) begin
					next_q.gate = 1'b1;
					next_q.sw = SW_RUN;
				end
			end
			default: next_q.sw = SW_RUN;
		endcase
		next_q.net = q.gate && cand[q.cur_sel];
		// reference mux and cascade path
		next_q.pll0_in = i_ref_clk[clkswitch];
		next_q.casc_active = q.ctrl[CTRL_CASCADE] && !q.ctrl[CTRL_XCVR]
			&& !PLL1_UPSTREAM_ONLY;
		next_q.casc_refused = q.ctrl[CTRL_CASCADE] && !next_q.casc_active;
		next_q.pll1_in = q.casc_active ? q.net : i_ref_clk[1];
		// register writes and read data capture
		if (wr_en && i_paddr == ADDR_CTRL) begin
			next_q.ctrl = i_pwdata[CTRL_W-1:0];
		end
		if (setup_rd) begin
			next_q.prdata = rd_value;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			q <= '0;
			q.dly <= CNT_INIT;
			q.tap <= TAP_INIT;
			q.ctrl <= CTRL_RESET;
			q.sw <= SW_RUN;
			q.ph <= PS_IDLE;
		end else begin
			q <= next_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_prdata = q.prdata;
	assign o_pready = i_psel && i_penable;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign o_global_clock_net = q.net;
	assign o_pll0_in = q.pll0_in;
	assign o_pll1_in = q.pll1_in;
	assign o_scan_clk = q.scan_clk;
	assign o_pll_clk = q.outc;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_sync);

	sequence sel_request_s;
		q.sw == SW_RUN && i_clk_select != q.cur_sel;
	endsequence
	sequence gate_dropped_s;
		q.sw == SW_OFF_WAIT ##1 q.sw == SW_ON_WAIT;
	endsequence

	sel_request_a: assert property (sel_request_s |=> q.sw == SW_OFF_WAIT)
		else $error("select change not taken");
	static_route_a: assert property (q.tap == $past(q.tap) ||
		$past(q.ph) == PS_STEP) else $error("tap moved without a step");
	net_gated_a: assert property (!q.gate |=> !q.net)
		else $error("net active while gated off");
	ref_mux_a: assert property ($past(rst_sync) |-> q.pll0_in ==
		$past(i_ref_clk[clkswitch])) else $error("reference mux wrong");
	tap_rise_a: assert property ($rose(q.outc[0][0]) |->
		$past(q.vco_phase) == $past(q.tap[0][0]))
		else $error("output rose off its tap");
	high_time_a: assert property (tick[0][0] && q.run[0][0] &&
		q.outc[0][0] && q.cnt[0][0] == HIGH_LAST |=> !q.outc[0][0])
		else $error("high time wrong");
	coarse_start_a: assert property ($rose(q.run[0][0]) |->
		$past(q.dly[0][0]) <= CNT_ONE) else $error("started early");
	step_time_a: assert property ($rose(q.ph == PS_STEP) |->
		##SCAN_CYC q.ph == PS_IDLE) else $error("step took wrong time");
	cascade_block_a: assert property (q.ctrl[CTRL_XCVR] |=>
		!q.casc_active) else $error("cascade in transceiver mode");
	switch_low_a: assert property (gate_dropped_s |-> !q.gate)
		else $error("switched with gate open");
	gate_rise_a: assert property ($rose(q.gate) |->
		!$past(cand[q.cur_sel])) else $error("gate opened on high clock");

	// counters, scan clock, pll inputs and the gate
	sequence scan_edge_s;
		$rose(q.scan_clk);
	endsequence

	low_time_a: assert property (tick[0][0] && q.run[0][0] &&
		!q.outc[0][0] && q.cnt[0][0] == LOW_LAST |=> q.outc[0][0])
		else $error("low time wrong");
	coarse_count_a: assert property (tick[0][2] && !q.run[0][2] &&
		q.dly[0][2] > CNT_ONE |=>
		q.dly[0][2] == $past(q.dly[0][2]) - CNT_ONE)
		else $error("coarse delay count wrong");
	scan_period_a: assert property (scan_edge_s |-> ##SCAN_CYC
		$rose(q.scan_clk)) else $error("scan clock period wrong");
	casc_path_a: assert property (q.casc_active |=>
		q.pll1_in == $past(q.net)) else $error("cascade path wrong");
	pll1_ref_a: assert property ($past(rst_sync) && !q.casc_active |=>
		q.pll1_in == $past(i_ref_clk[1])) else $error("pll1 input wrong");
	gate_on_a: assert property (q.gate |-> q.on)
		else $error("gate open with net off");
	net_follow_a: assert property (q.gate |=>
		q.net == $past(cand[q.cur_sel])) else $error("net lost its source");

endmodule // global_clock_net_ctrl

// File: global_clock_net_ctrl_pkg.sv
// constants and types shared by the global clock control block
package global_clock_net_ctrl_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PHASE = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_TAP0 = 8'h0C;
	localparam logic [7:0] ADDR_TAP1 = 8'h10;
	// control register fields
	localparam int CTRL_W = 4;
	localparam int CTRL_MANUAL = 0;
	localparam int CTRL_SWITCH = 1;
	localparam int CTRL_CASCADE = 2;
	localparam int CTRL_XCVR = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	// phase register fields
	localparam int PH_GO = 0;
	localparam int PH_UP = 1;
	localparam int PH_PLL = 4;
	localparam int PH_CNT_LSB = 8;
	// status register fields
	localparam int ST_SEL_LSB = 0;
	localparam int ST_ON = 2;
	localparam int ST_SWITCHING = 3;
	localparam int ST_PH_BUSY = 4;
	localparam int ST_CASC = 5;
	localparam int ST_CASC_REFUSED = 6;
	// pll structure
	localparam int NUM_PLL = 2;
	localparam int NUM_CNT = 5;
	localparam int NUM_TAP = 8;
	localparam int TAP_W = 3;
	localparam int CNT_W = 8;
	localparam int CNT_SEL_W = 3;
	localparam logic [TAP_W-1:0] TAP_ONE = 3'h1;
	localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	// scan clock timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SCAN_PERIOD_NS = 40;
	localparam int SCAN_HALF = SCAN_PERIOD_NS / CLK_PERIOD_NS / 2;
	localparam int SCAN_W = 4;
	localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(SCAN_HALF - 1);
	localparam logic [SCAN_W-1:0] SCAN_ZERO = 4'h0;
	// state machines
	typedef enum logic [1:0] {SW_RUN, SW_OFF_WAIT, SW_ON_WAIT} sw_state_type;
	typedef enum logic [1:0] {PS_IDLE, PS_ALIGN, PS_STEP} ph_state_type;
endpackage

// File: user_logic_model.sv
// user logic model that drives the clock select and net enable
`timescale 1ns/1ps
module user_logic_model (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [1:0] i_want_sel,
	input wire logic i_want_en,
	input wire logic [3:0] i_lag,
	output logic [1:0] o_clk_select,
	output logic o_net_enable
);
	logic [3:0] wait_cnt;
	// apply a request after a programmable lag, then hold it steady
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_clk_select <= 2'h0;
			o_net_enable <= 1'b0;
			wait_cnt <= 4'h0;
		end else if ({i_want_sel, i_want_en} == {o_clk_select, o_net_enable})
		begin
			wait_cnt <= 4'h0;
		end else if (wait_cnt >= i_lag) begin
			o_clk_select <= i_want_sel;
			o_net_enable <= i_want_en;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule // user_logic_model

// File: tb.sv
// self-checking bench for the global clock control block
`timescale 1ns/1ps
module tb;
	import global_clock_net_ctrl_pkg::*;
	logic i_clk = 1'b0, i_rst_b = 1'b0, i_psel = 1'b0, i_penable = 1'b0;
	logic i_pwrite = 1'b0, want_en = 1'b0, ref_prev;
	logic [7:0] i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, q;
	logic [1:0] i_ref_clk = 2'h0, want_sel = 2'h0, clk_select;
	logic [3:0] lag = 4'h0;
	logic o_pready, o_pslverr, net_enable, o_global_clock_net, o_pll0_in;
	logic o_pll1_in, o_scan_clk;
	logic [NUM_PLL*NUM_CNT-1:0] o_pll_clk;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int err_count = 0, n_tests = 0, seed = 32'h8C194C25, c1, c2;
	////////////////////////////////////////////////////////////////////////
	// clock, random reference inputs and the two instances
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) i_ref_clk <= 2'($random(seed));
	global_clock_net_ctrl #(
		.CNT_INIT(80'h01010101010101030101),
		.TAP_INIT(30'h00000018)
	) global_clock_net_ctrl_inst (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
		.o_pslverr(o_pslverr), .i_clk_select(clk_select),
		.i_net_enable(net_enable), .i_ref_clk(i_ref_clk),
		.o_global_clock_net(o_global_clock_net), .o_pll0_in(o_pll0_in),
		.o_pll1_in(o_pll1_in), .o_scan_clk(o_scan_clk),
		.o_pll_clk(o_pll_clk)
	);
	user_logic_model user_logic_model_inst (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_want_sel(want_sel),
		.i_want_en(want_en), .i_lag(lag), .o_clk_select(clk_select),
		.o_net_enable(net_enable)
	);
	////////////////////////////////////////////////////////////////////////
	// compare each read answer with the oldest expectation unless that expectation has bit 33 set
	always @(posedge i_clk) begin
		if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
			e = exp_q.pop_front();
			if (!e[33])
				check({o_pslverr, o_prdata}, e[32:0]);
		end
	end
	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [33:0] x);
		int n = 0;
		if (!w)
			exp_q.push_back(x);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (o_pready !== 1'b1)
			err_count++;
		q = o_prdata;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] x);
		apb(1'b0, a, 32'h0, {1'b0, x});
	endtask
	// each pll input repeats its chosen source one clock later
	task automatic follow(input int k, input int s);
		logic want;
		repeat (16) begin
			@(posedge i_clk);
			want = k ? (s ? o_global_clock_net : i_ref_clk[1]) : i_ref_clk[s];
			#1;
			check(33'(k ? o_pll1_in : o_pll0_in), 33'(want));
		end
	endtask
	// read until a flag clears, under a bounded count
	task automatic poll(input logic [7:0] a, input int b);
		int n = 0;
		q = 32'hFFFFFFFF;
		while (q[b] !== 1'b0 && n < 100) begin
			apb(1'b0, a, 32'h0, 34'h200000000);
			n++;
		end
		check({32'h0, q[b]}, 33'h0);
	endtask
	// count cycles until a counter output reaches a level
	task automatic lvl(input int j, input logic v, output int c);
		c = 0;
		while (o_pll_clk[j] !== v && c < 100) begin
			@(posedge i_clk);
			#1;
			c++;
		end
	endtask
	// align on a rise of counter 0, then count cycles until counter j falls, then until it rises again
	task automatic offset(input int j, output int lo, output int hi);
		lvl(0, 1'b0, lo);
		lvl(0, 1'b1, lo);
		lvl(j, 1'b0, lo);
		lvl(j, 1'b1, hi);
	endtask
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (5) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(ADDR_CTRL, 33'h0);
		wr(ADDR_STATUS, 32'hFFFFFFFF);
		rd(ADDR_STATUS, 33'h0);
		rd(ADDR_TAP0, 33'h18);
		rd(ADDR_TAP1, 33'h0);
		wr(8'h14, 32'h1);
		rd(8'h14, {1'b1, 32'h0});
		$display("done: register map");
		offset(0, c1, c2);
		check(33'(c1), 33'h10);
		check(33'(c2), 33'h10);
		offset(1, c1, c2);
		check(33'(c1 + c2), 33'h3);
		offset(2, c1, c2);
		check(33'(c1 + c2), 33'h10);
		@(posedge i_clk);
		$display("done: counter phases");
		for (int i = 3; i >= 0; i--) begin
			lag <= 4'($random(seed) & 7);
			want_sel <= 2'(i);
			want_en <= (i != 2);
			repeat (12) @(posedge i_clk);
			poll(ADDR_STATUS, ST_SWITCHING);
			rd(ADDR_STATUS, {30'h0, i != 2, 2'(i)});
			c1 = 0;
			repeat (40) begin
				@(posedge i_clk);
				c1 += (o_global_clock_net === 1'b1);
			end
			check(33'(c1 == 0), 33'(i == 2));
		end
		$display("done: source select");
		follow(0, 0);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CTRL, 32'(1 + 2 * s));
			follow(0, s);
			@(posedge i_clk);
		end
		$display("done: reference mux");
		wr(ADDR_PHASE, 32'h00000103);
		rd(ADDR_PHASE, 33'h103);
		poll(ADDR_PHASE, PH_GO);
		rd(ADDR_TAP0, 33'h20);
		wr(ADDR_PHASE, 32'h00000011);
		poll(ADDR_PHASE, PH_GO);
		rd(ADDR_TAP1, 33'h7);
		// scan clock: one rise per scan period, half of it high
		c1 = 0;
		c2 = 0;
		ref_prev = o_scan_clk;
		repeat (40) begin
			@(posedge i_clk);
			#1;
			c1 += (o_scan_clk === 1'b1);
			c2 += (o_scan_clk === 1'b1 && ref_prev === 1'b0);
			ref_prev = o_scan_clk;
		end
		check(33'(c1), 33'(20));
		check(33'(c2), 33'(40 * CLK_PERIOD_NS / SCAN_PERIOD_NS));
		$display("done: phase steps");
		wr(ADDR_CTRL, 32'h4);
		rd(ADDR_STATUS, 33'h24);
		follow(1, 1);
		wr(ADDR_CTRL, 32'hC);
		rd(ADDR_STATUS, 33'h44);
		follow(1, 0);
		$display("done: cascade");
		close_out();
	end
	// watchdog against a hang
	initial begin
		#300000;
		err_count++;
		close_out();
	end
endmodule // tb
